// File: rtl/casl_pkg.sv
// casl_pkg: shared constants for the channel address select logic
package casl_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned DEV_CLK_HZ     = 5_000_000;
  localparam int unsigned DEV_CLK_DIV    = CLK_HZ / DEV_CLK_HZ;
  localparam int unsigned HOLD_TMO_SEC   = 5;
  // longest time rounds down; counted in device clock ticks
  localparam int unsigned HOLD_TMO_TICKS = HOLD_TMO_SEC * DEV_CLK_HZ;

  // ---------------------------------------------------------------
  // address field layout
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned CU_LSB     = 4;
  localparam int unsigned DEV_LSB    = 0;
  localparam int unsigned CU_DECODES = 16;
  localparam int unsigned CU_SLOTS   = 8;

  // host write location that carries the timeout disable bit
  localparam logic [4:0] LOC_TMO_DISABLE = 5'h18;
  localparam int unsigned TMO_DISABLE_BIT = 3;

endpackage

// File: rtl/casl_parity.sv
// casl_parity: odd parity check and generation for a channel byte
`timescale 1ns/1ps
module casl_parity
  import casl_pkg::*;
#(
  parameter int unsigned WIDTH = ADDR_W
) (
  // byte and its parity
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             par_i,
  // results
  output logic                  par_good_o,
  output logic                  par_gen_o
);

  initial begin
    if (WIDTH < 1) begin
      $error("casl_parity: WIDTH must be at least 1");
    end
  end

  // odd total count of ones means good; generated bit makes it odd
  assign par_good_o = ^{data_i, par_i};
  assign par_gen_o  = ~(^data_i);

endmodule

// File: rtl/casl_hold_timer.sv
// casl_hold_timer: channel hold timeout counter on the device clock
`timescale 1ns/1ps
module casl_hold_timer
  import casl_pkg::*;
#(
  parameter int unsigned TICKS = HOLD_TMO_TICKS
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  // controls
  input  wire logic tick_i,
  input  wire logic clear_i,
  input  wire logic op_in_i,
  input  wire logic disable_i,
  // result
  output logic      expired_o
);

  localparam int unsigned CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(TICKS);

  initial begin
    if (TICKS < 1) begin
      $error("casl_hold_timer: TICKS must be at least 1");
    end
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          exp_r;
  logic          exp_nxt;
  wire           at_end = (cnt_r == LAST);

  // restart on lowered op-in; held at zero while disabled
  assign cnt_nxt = (!op_in_i || disable_i) ? '0 :
                   (tick_i && !at_end) ? cnt_r + 1'b1 : cnt_r;
  // sticky until reset or init clears it
  assign exp_nxt = clear_i ? 1'b0 :
                   (exp_r || (at_end && op_in_i && !disable_i));

  // counter and timeout flag
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= clear_i ? '0 : cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired_o = exp_r;

endmodule

// File: rtl/casl_top.sv
// casl_top: channel address recognition, select chain and hold timeout
//
// Summary of operation
// - decoder enabled only with address tag and good parity
// - address byte plus parity must be odd
// - check outbound parity, generate inbound parity
// - channel bit 0 becomes internal bit 7
// - high nibble unit, low nibble device
// - sixteen unit decodes, eight strapped slots
// - OR selected decodes, AND with device digit
// - device digit forced or compared with register
// - both matches drive phase 1 and 2 exit
// - operational-in held too long raises the sticky hold timeout flag
// - location 24 write loads bit 3 disable
// - timeout cleared by reset or initialize
// - recognised select captured, otherwise passed downstream
// - offline or unpowered bypasses select capture
// - online and power good routes select inward
// - hold-out keeps capture; drop releases at once
// - everything runs on the 20 MHz mclk, paced by a 5 MHz device tick
`timescale 1ns/1ps
module casl_top
  import casl_pkg::*;
#(
  parameter int unsigned SLOTS      = CU_SLOTS,
  parameter int unsigned TMO_TICKS  = HOLD_TMO_TICKS
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              arst_n_i,
  // channel outbound side, channel numbering bit 0 first
  input  wire logic [ADDR_W-1:0] channel_outbound_bus_i,
  input  wire logic              outbound_parity_bit_i,
  input  wire logic              address_tag_active_i,
  input  wire logic              select_out_i,
  input  wire logic              hold_out_tag_i,
  // channel inbound side
  input  wire logic [ADDR_W-1:0] inbound_data_i,
  output logic [ADDR_W-1:0]      channel_inbound_bus_o,
  output logic                   inbound_parity_o,
  // select chain to next control unit
  output logic                   select_out_next_o,
  // straps and configuration
  input  wire logic [NIB_W-1:0]  cu_strap_i [CU_SLOTS],
  input  wire logic              dev_digit_ignore_i,
  input  wire logic [ADDR_W-1:0] unit_address_register_i,
  // status of the unit
  input  wire logic              online_i,
  input  wire logic              dc_power_low_i,
  input  wire logic              operational_in_i,
  // host write port for the timeout disable
  input  wire logic              host_wr_i,
  input  wire logic [4:0]        host_loc_i,
  input  wire logic [15:0]       host_wdata_i,
  input  wire logic              host_init_i,
  // results
  output logic                   address_parity_good_o,
  output logic                   unit_address_match_o,
  output logic                   device_address_match_o,
  output logic                   select_capture_flop_o,
  output logic                   hold_timeout_o,
  output logic                   hold_timeout_disable_o,
  output logic                   dev_tick_o
);

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  // refuse settings that the slot table or the counters cannot serve
  initial begin
    if (SLOTS < 1 || SLOTS > CU_SLOTS) begin
      $error("casl_top: SLOTS must be 1 to 8");
    end
    if (DEV_CLK_DIV < 1) begin
      $error("casl_top: device clock divider below one");
    end
    if (TMO_TICKS < 1) begin
      $error("casl_top: TMO_TICKS must be at least 1");
    end
  end

  // -----------------------------------------------------------------
  // functions
  // -----------------------------------------------------------------
  // renumber channel bits: channel bit i lands on internal bit 7-i
  // one function serves both directions, so the two maps cannot drift
  function automatic logic [ADDR_W-1:0] renumber(
    input logic [ADDR_W-1:0] v
  );
    logic [ADDR_W-1:0] r;
    r = '0;
    for (int i = 0; i < ADDR_W; i++) begin
      r[ADDR_W-1-i] = v[i];
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // device clock enable
  // -----------------------------------------------------------------
  localparam int unsigned DW = (DEV_CLK_DIV > 1) ? $clog2(DEV_CLK_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DEV_CLK_DIV - 1);

  logic [DW-1:0] div_r;
  logic [DW-1:0] div_nxt;
  wire           tick = (div_r == DIV_LAST);

  assign div_nxt = tick ? '0 : div_r + 1'b1;

  // one 5 MHz enable paces all channel strobing
  // a pulse, not a derived clock: both sides keep one timing reference
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign dev_tick_o = tick;

  // -----------------------------------------------------------------
  // parity
  // -----------------------------------------------------------------
  wire [ADDR_W-1:0] addr_int = renumber(channel_outbound_bus_i);
  wire              par_good;
  wire              in_par;

  // renumbering keeps the count of ones, so the raw byte is checked
  // outbound check, odd total required
  casl_parity #(
    .WIDTH      (ADDR_W)
  ) u_par_out (
    .data_i     (channel_outbound_bus_i),
    .par_i      (outbound_parity_bit_i),
    .par_good_o (par_good),
    .par_gen_o  ()
  );

  // inbound generation on the bus we drive
  casl_parity #(
    .WIDTH      (ADDR_W)
  ) u_par_in (
    .data_i     (inbound_data_i),
    .par_i      (1'b0),
    .par_good_o (),
    .par_gen_o  (in_par)
  );

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire [NIB_W-1:0] cu_nib  = addr_int[CU_LSB +: NIB_W];
  wire [NIB_W-1:0] dev_nib = addr_int[DEV_LSB +: NIB_W];
  wire             dec_en  = address_tag_active_i && par_good;
  wire [CU_DECODES-1:0] cu_onehot;
  wire [CU_SLOTS-1:0]   slot_hit;

  // without a tag or good parity the decode stays dark, so a byte
  // passing on an idle bus can never reach the match logic
  // full sixteen-way decode, gated by the enable
  genvar g;
  generate
    for (g = 0; g < CU_DECODES; g++) begin : g_dec
      assign cu_onehot[g] = dec_en && (cu_nib == NIB_W'(g));
    end
    // each slot picks one of the sixteen decodes through its strap
    // unused slots repeat the last used strap
    for (g = 0; g < CU_SLOTS; g++) begin : g_slot
      if (g < SLOTS) begin : g_use
        assign slot_hit[g] = cu_onehot[cu_strap_i[g]];
      end else begin : g_rep
        assign slot_hit[g] = cu_onehot[cu_strap_i[SLOTS-1]];
      end
    end
  endgenerate

  // any strapped slot that fires counts as a unit decode hit; the unit match also needs dev_cmp
  wire cu_any  = |slot_hit;
  // forced match or compare with low register bits
  wire dev_cmp = dev_digit_ignore_i ||
                 (dev_nib == unit_address_register_i[NIB_W-1:0]);
  // the device term is repeated on purpose: the unit match already
  // carries the digit compare, just as the two-legged gate does
  wire ua_hit  = cu_any && dev_cmp;
  wire da_hit  = dev_cmp && ua_hit;

  // -----------------------------------------------------------------
  // sampled match results
  // -----------------------------------------------------------------
  logic par_good_r;
  logic ua_r;
  logic da_r;
  wire  sample = tick && address_tag_active_i;

  // held values spare the phase logic a bus that changes under it;
  // the cost is up to one device tick of latency after the tag
  // sample on the tagged edge, hold for the phase logic
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      par_good_r <= 1'b0;
      ua_r       <= 1'b0;
      da_r       <= 1'b0;
    end else if (sample) begin
      par_good_r <= par_good;
      ua_r       <= ua_hit;
      da_r       <= da_hit;
    end
  end

  assign address_parity_good_o  = par_good_r;
  assign unit_address_match_o   = ua_r;
  assign device_address_match_o = da_r;

  // -----------------------------------------------------------------
  // inbound bus
  // -----------------------------------------------------------------
  logic [ADDR_W-1:0] in_bus_r;
  logic              in_par_r;

  // limitation: inbound data is taken on the tick only, so a byte
  // must stand for a whole device clock period to be sent
  // inbound data goes out in channel numbering
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_bus_r <= '0;
      in_par_r <= 1'b1;
    end else if (tick) begin
      in_bus_r <= renumber(inbound_data_i);
      in_par_r <= in_par;
    end
  end

  // inbound outputs come straight from flip-flops
  assign channel_inbound_bus_o = in_bus_r;
  assign inbound_parity_o      = in_par_r;

  // -----------------------------------------------------------------
  // select chain
  // -----------------------------------------------------------------
  // powered and online switches select inward; else straight through
  wire sel_in_path = online_i && !dc_power_low_i;
  logic sel_r;
  logic sel_nxt;

  // hold-out only keeps a capture; it never makes one on its own
  // capture on recognition, kept by hold-out, dropped with select
  assign sel_nxt = sel_in_path && select_out_i &&
                   ((tick && address_tag_active_i && ua_hit) ||
                    (sel_r && hold_out_tag_i));

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // the live match blocks the pass at once, before the flip-flop
  // fills, so the next unit never sees a runt select pulse
  // pass downstream unless captured; last unit loops to select-in
  assign select_out_next_o = sel_in_path ? (select_out_i && !sel_r &&
                             !(address_tag_active_i && ua_hit))
                           : select_out_i;
  assign select_capture_flop_o = sel_r;

  // -----------------------------------------------------------------
  // hold timeout
  // -----------------------------------------------------------------
  logic tmo_dis_r;
  wire  wr_loc24 = host_wr_i && (host_loc_i == LOC_TMO_DISABLE);

  // init leaves this flag alone; only a reset or a new write moves it
  // write to location 24 loads data bit 3
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmo_dis_r <= 1'b0;
    end else if (wr_loc24) begin
      tmo_dis_r <= host_wdata_i[TMO_DISABLE_BIT];
    end
  end

  assign hold_timeout_disable_o = tmo_dis_r;

  // the counter advances on the tick, so its limit is in device clocks
  // reset handled inside, init clears the flag
  casl_hold_timer #(
    .TICKS     (TMO_TICKS)
  ) u_tmo (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .tick_i    (tick),
    .clear_i   (host_init_i),
    .op_in_i   (operational_in_i),
    .disable_i (tmo_dis_r),
    .expired_o (hold_timeout_o)
  );

endmodule

// File: sim/casl_chan_model.sv
// casl_chan_model: channel side that tags an address and selects
`timescale 1ns/1ps
module casl_chan_model (
  // clock and commands from the bench
  input  wire logic       mclk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       bad_par_i,
  // channel lines toward the unit
  output logic [7:0]      bus_o,
  output logic            par_o,
  output logic            tag_o,
  output logic            sel_o,
  output logic            hold_o,
  // end of the chain
  input  wire logic       sel_next_i,
  output logic            sel_in_o
);
  // ----------------------------------------------------------------
  // channel drive
  // ----------------------------------------------------------------
  logic go_r;
  initial begin
    go_r = 1'h0;
    bus_o = 8'h5a;
    par_o = 1'h0;
    tag_o = 1'h0;
    sel_o = 1'h0;
    hold_o = 1'h0;
  end
  // commands taken on the rise, lines moved on the fall
  always @(posedge mclk_i) go_r <= go_i;
  always @(negedge mclk_i) begin
    if (go_r) begin
      bus_o <= {<<{addr_i}};
      par_o <= ~^addr_i ^ bad_par_i;
    end else begin
      bus_o <= ~bus_o;  // a released bus toggles between the stale byte and its complement
      par_o <= ~par_o;
    end
    tag_o <= go_r;
    sel_o <= go_r;
    hold_o <= go_r;
  end
  // jumper on the last unit turns select back to the channel
  assign sel_in_o = sel_next_i;
endmodule

// File: sim/casl_monitor.sv
// casl_monitor: port assertions for the channel address select logic
`timescale 1ns/1ps
module casl_monitor
  import casl_pkg::*;
#(
  parameter int unsigned SLOTS     = CU_SLOTS,
  parameter int unsigned TMO_TICKS = HOLD_TMO_TICKS
) (
  // clock, reset and watched ports
  input wire logic              mclk_i,
  input wire logic              arst_n_i,
  input wire logic [ADDR_W-1:0] channel_outbound_bus_i,
  input wire logic              outbound_parity_bit_i,
  input wire logic              address_tag_active_i,
  input wire logic              select_out_i,
  input wire logic [ADDR_W-1:0] channel_inbound_bus_o,
  input wire logic              inbound_parity_o,
  input wire logic              select_out_next_o,
  input wire logic              dev_digit_ignore_i,
  input wire logic [ADDR_W-1:0] unit_address_register_i,
  input wire logic              online_i,
  input wire logic              dc_power_low_i,
  input wire logic              host_wr_i,
  input wire logic [4:0]        host_loc_i,
  input wire logic [15:0]       host_wdata_i,
  input wire logic              host_init_i,
  input wire logic              address_parity_good_o,
  input wire logic              unit_address_match_o,
  input wire logic              device_address_match_o,
  input wire logic              select_capture_flop_o,
  input wire logic              hold_timeout_o,
  input wire logic              hold_timeout_disable_o,
  input wire logic              dev_tick_o
);
  // ----------------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------------
  wire       odd_in = ^{channel_outbound_bus_i, outbound_parity_bit_i};
  wire       wd3 = host_wdata_i[TMO_DISABLE_BIT];
  // device nibble in internal numbering, channel bits reversed
  wire [3:0] dnib = {channel_outbound_bus_i[4], channel_outbound_bus_i[5],
                     channel_outbound_bus_i[6], channel_outbound_bus_i[7]};
  wire       samp = dev_tick_o && address_tag_active_i;
  wire       lose = dnib != unit_address_register_i[3:0];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  property p_par;
    samp |=> address_parity_good_o == $past(odd_in);
  endproperty
  a_par: assert property (p_par)
    else $error("parity flag wrong");
  property p_gate;
    unit_address_match_o |-> address_parity_good_o;
  endproperty
  a_gate: assert property (p_gate)
    else $error("match bad parity");
  property p_and;
    device_address_match_o |-> unit_address_match_o;
  endproperty
  a_and: assert property (p_and)
    else $error("device without unit");
  property p_dig;
    samp && !dev_digit_ignore_i && lose |=> !device_address_match_o;
  endproperty
  a_dig: assert property (p_dig)
    else $error("device digit ignored");
  property p_unit;
    samp && !dev_digit_ignore_i && lose |=> !unit_address_match_o;
  endproperty
  a_unit: assert property (p_unit)
    else $error("unit match without digit");
  property p_byp;
    !online_i || dc_power_low_i |-> select_out_next_o == select_out_i;
  endproperty
  a_byp: assert property (p_byp)
    else $error("select not bypassed");
  property p_seize;
    select_capture_flop_o && online_i && !dc_power_low_i |->
      !select_out_next_o;
  endproperty
  a_seize: assert property (p_seize)
    else $error("select leaked");
  property p_rel;
    !select_out_i |=> !select_capture_flop_o;
  endproperty
  a_rel: assert property (p_rel)
    else $error("capture kept");
  property p_tick;
    dev_tick_o |=> !dev_tick_o [*3] ##1 dev_tick_o;
  endproperty
  a_tick: assert property (p_tick)
    else $error("tick period");
  property p_init;
    host_init_i |=> !hold_timeout_o;
  endproperty
  a_init: assert property (p_init)
    else $error("timeout not cleared");
  property p_dis;
    host_wr_i && host_loc_i == LOC_TMO_DISABLE |=>
      hold_timeout_disable_o == $past(wd3);
  endproperty
  a_dis: assert property (p_dis)
    else $error("disable not loaded");
  property p_stk;
    hold_timeout_o && !host_init_i |=> hold_timeout_o;
  endproperty
  a_stk: assert property (p_stk)
    else $error("timeout not sticky");
  property p_odd;
    ^{channel_inbound_bus_o, inbound_parity_o};
  endproperty
  a_odd: assert property (p_odd)
    else $error("inbound parity even");
  c_cap: cover property ($rose(select_capture_flop_o));
  c_tmo: cover property ($rose(hold_timeout_o));
  c_byp: cover property (!online_i && select_out_next_o);
endmodule

bind casl_top casl_monitor #(.SLOTS(SLOTS), .TMO_TICKS(TMO_TICKS))
  casl_monitor_inst (.*);

// File: sim/channel_address_select_logic_tb_top.sv
// channel_address_select_logic_tb_top: self-checking bench
`timescale 1ns/1ps
module channel_address_select_logic_tb_top;
  import casl_pkg::*;
  // ----------------------------------------------------------------
  // signals and table
  // ----------------------------------------------------------------
  localparam int unsigned TMO = 20;  // short limit keeps the run brief
  // flag field: bad parity, ignore digit, then expected pg, um, dm
  typedef struct packed {
    logic [7:0] a;
    logic [4:0] f;
  } casl_row_t;
  casl_row_t  rows [7] = '{'{8'h13, 5'h07}, '{8'h14, 5'h04},
    '{8'h53, 5'h07}, '{8'h23, 5'h04}, '{8'h13, 5'h10},
    '{8'h5e, 5'h0f}, '{8'hf3, 5'h04}};
  logic [4:0] wl [4] = '{5'h18, 5'h17, 5'h18, 5'h18};
  logic [15:0] wd [4] = '{16'h0008, 16'h0000, 16'hfff7, 16'h0008};
  logic [3:0] wexp = 4'hb;
  logic [3:0] strap [8] = '{4'h1, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'h5};
  logic       mclk_i = 1'h0;
  logic       arst_n_i = 1'h0;
  logic [7:0] bus, inb, uar, inb_bus, addr;
  logic [4:0] hloc;
  logic [15:0] hwd;
  logic par, tag, sel, hold, ign, online, dcl, opin, hwr, hinit, go, badp;
  logic sel_in, inb_par, sel_next, pg, um, dm, cap, tmo, tdis, tick;
  int   errors = 0;
  int   checks = 0;
  int   n;

  casl_top #(.TMO_TICKS(TMO)) casl_top_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .channel_outbound_bus_i(bus), .outbound_parity_bit_i(par),
    .address_tag_active_i(tag), .select_out_i(sel), .hold_out_tag_i(hold),
    .inbound_data_i(inb), .channel_inbound_bus_o(inb_bus),
    .inbound_parity_o(inb_par), .select_out_next_o(sel_next),
    .cu_strap_i(strap), .dev_digit_ignore_i(ign),
    .unit_address_register_i(uar), .online_i(online),
    .dc_power_low_i(dcl), .operational_in_i(opin), .host_wr_i(hwr),
    .host_loc_i(hloc), .host_wdata_i(hwd), .host_init_i(hinit),
    .address_parity_good_o(pg), .unit_address_match_o(um),
    .device_address_match_o(dm), .select_capture_flop_o(cap),
    .hold_timeout_o(tmo), .hold_timeout_disable_o(tdis), .dev_tick_o(tick));

  casl_chan_model casl_chan_model_inst (
    .mclk_i(mclk_i), .go_i(go), .addr_i(addr), .bad_par_i(badp),
    .bus_o(bus), .par_o(par), .tag_o(tag), .sel_o(sel), .hold_o(hold),
    .sel_next_i(sel_next), .sel_in_o(sel_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  always #25 mclk_i = ~mclk_i;
  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int j = 0; j < 8; j++) rev8[j] = v[7-j];
  endfunction
  // wait the given count of negedges; no check is made here
  task automatic idle(input int c);
    repeat (c) @(negedge mclk_i);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {inb, uar, addr, hloc, hwd} = '0;
    {ign, dcl, opin, hwr, hinit, go, badp} = '0;
    uar = 8'h03;
    online = 1'h1;
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i);
    arst_n_i = 1'h1;
    chk1("parity_good", 1'h0, pg);
    chk1("inbound_parity", 1'h1, inb_par);
    foreach (rows[i]) begin
      {badp, ign} = rows[i].f[4:3];
      addr = rows[i].a;
      inb = rows[i].a;
      go = 1'h1;
      idle(12);
      chk1("parity_good", rows[i].f[2], pg);
      chk1("unit_match", rows[i].f[1], um);
      chk1("device_match", rows[i].f[0], dm);
      chk1("capture", rows[i].f[0], cap);
      chk1("select_in", !rows[i].f[0], sel_in);
      chk8("inbound_bus", rev8(rows[i].a), inb_bus);
      chk1("inbound_parity", ~^rows[i].a, inb_par);
      go = 1'h0;
      idle(4);
      chk1("capture_release", 1'h0, cap);
    end
    // offline, then power low: select must run straight through
    for (int k = 0; k < 2; k++) begin
      {online, dcl} = {k[0], k[0]};
      {ign, badp, addr} = 10'h013;
      go = 1'h1;
      idle(12);
      chk1("bypass", 1'h1, sel_next);
      chk1("bypass_capture", 1'h0, cap);
      go = 1'h0;
      idle(4);
    end
    {online, dcl} = 2'h2;
    opin = 1'h1;
    idle(TMO * 4 - 8);
    chk1("timeout_early", 1'h0, tmo);
    n = 0;
    while (tmo !== 1'h1 && n < 40) begin
      idle(1);
      n++;
    end
    chk1("timeout", 1'h1, tmo);
    if (n == 40) conclude();
    opin = 1'h0;
    idle(8);
    chk1("timeout_sticky", 1'h1, tmo);
    hinit = 1'h1;
    idle(1);
    hinit = 1'h0;
    chk1("timeout_init", 1'h0, tmo);
    // location writes: only location 24 moves the disable flag
    for (int k = 0; k < 4; k++) begin
      {hwr, hloc, hwd} = {1'h1, wl[k], wd[k]};
      idle(1);
      hwr = 1'h0;
      idle(1);
      chk1("disable", wexp[k], tdis);
    end
    opin = 1'h1;
    idle(TMO * 4 + 40);
    chk1("timeout_disabled", 1'h0, tmo);
    {hwr, hloc, hwd} = {1'h1, 5'h18, 16'h0000};
    idle(1);
    hwr = 1'h0;
    // drop operational-in briefly: the count must start over
    idle(TMO * 2 + 20);
    opin = 1'h0;
    idle(8);
    opin = 1'h1;
    idle(TMO * 2 + 20);
    chk1("timeout_restart", 1'h0, tmo);
    // the restarted count still expires once the full limit has run
    idle(40);
    chk1("timeout_again", 1'h1, tmo);
    opin = 1'h0;
    // mid-run reset clears the flag and registered outputs; inbound parity resets to one
    arst_n_i = 1'h0;
    idle(2);
    arst_n_i = 1'h1;
    chk1("reset_timeout", 1'h0, tmo);
    chk1("reset_unit_match", 1'h0, um);
    chk1("reset_capture", 1'h0, cap);
    chk8("reset_inbound_bus", 8'h00, inb_bus);
    chk1("reset_inbound_parity", 1'h1, inb_par);
    idle(8);
    conclude();
  end
endmodule
